// *** design/prc_clock_detect.sv ***
`timescale 1ns/1ps
`include "prc_defines.svh"

module prc_clock_detect
  import prc_pkg::*;
#(
  parameter int RW = 10,
  parameter int CW = 16
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_clear,
  // timing ticks
  input  wire logic       i_mclk_tick,
  input  wire logic       i_fs_tick,
  // detected codes
  output logic [3:0]      o_ratio_code_q,
  output logic [1:0]      o_rate_code_q,
  output logic            o_locked_q
);

  prc_det_st_t   st_q;      // measuring once a frame edge was seen
  logic [RW-1:0] mcnt_q;    // master ticks in this frame
  logic [CW-1:0] ccnt_q;    // system cycles in this frame

  // map master ticks per frame to a ratio code, f for unknown
  function automatic logic [3:0] code_of(input logic [RW-1:0] n);
    case (n)
      RW'(64):  code_of = 4'h0;
      RW'(128): code_of = 4'h1;
      RW'(256): code_of = 4'h2;
      RW'(384): code_of = 4'h3;
      RW'(512): code_of = 4'h4;
      RW'(768): code_of = 4'h5;
      RW'(100): code_of = 4'h6;
      RW'(200): code_of = 4'h7;
      RW'(400): code_of = 4'h8;
      default:  code_of = 4'hf;
    endcase
  endfunction

  wire [3:0] meas_code = code_of(mcnt_q);
  wire       m_full    = &mcnt_q;
  wire       c_full    = &ccnt_q;
  wire [1:0] meas_rate = (ccnt_q < CW'(`PRC_MID_CYC)) ? `PRC_RATE_48K :
                         (ccnt_q < CW'(`PRC_LOW_CYC)) ? `PRC_RATE_24K :
                                                        `PRC_RATE_12K;
  wire       frame_end = i_fs_tick && (st_q == PRC_ST_MEAS);

  // ------------------------------------------------------------
  // frame measurement
  // ------------------------------------------------------------
  // an unknown ratio keeps the last good code
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q           <= PRC_ST_WAIT;
      mcnt_q         <= '0;
      ccnt_q         <= '0;
      o_ratio_code_q <= 4'h2;
      o_rate_code_q  <= `PRC_RATE_48K;
      o_locked_q     <= 1'b0;
    end else if (i_clear) begin
      st_q       <= PRC_ST_WAIT;
      mcnt_q     <= '0;
      ccnt_q     <= '0;
      o_locked_q <= 1'b0;
    end else begin
      case (st_q)
        PRC_ST_WAIT: begin
          // the tick on the frame edge belongs to the new frame
          if (i_fs_tick) begin
            st_q   <= PRC_ST_MEAS;
            mcnt_q <= RW'(i_mclk_tick);
            ccnt_q <= CW'(1);
          end else begin
            mcnt_q <= '0;
            ccnt_q <= '0;
          end
        end
        PRC_ST_MEAS: begin
          if (frame_end) begin
            // count the edge cycle too, else every frame reads one short
            mcnt_q <= RW'(i_mclk_tick);
            ccnt_q <= CW'(1);
            o_rate_code_q <= meas_rate;
            o_locked_q    <= (meas_code != 4'hf);
            if (meas_code != 4'hf) begin
              o_ratio_code_q <= meas_code;
            end
          end else begin
            mcnt_q <= mcnt_q + RW'(i_mclk_tick && !m_full);
            ccnt_q <= ccnt_q + CW'(!c_full);
          end
        end
        default: begin
          st_q <= PRC_ST_WAIT;
        end
      endcase
    end
  end

endmodule

// *** design/prc_config_regs.sv ***
`timescale 1ns/1ps
`include "prc_defines.svh"

module prc_config_regs
  import prc_pkg::*;
#(
  parameter int SILENT_SAMPLES = `PRC_SILENT_SAMPLES
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // register port from the control bus slave
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic [7:0]      o_reg_rdata_q,
  output logic            o_reg_ack_q,
  output logic            o_reg_nack_q,
  // audio side status
  input  wire logic [1:0] i_fmt_rate,
  input  wire logic       i_smp_valid,
  input  wire logic       i_smp_zero,
  input  wire logic       i_mclk_tick,
  input  wire logic       i_fs_tick,
  // settings to the datapath
  output logic            o_soft_rst_q,
  output logic            o_core_pdn_q,
  output logic            o_mclk_as_bclk_q,
  output logic [9:0]      o_ratio_mult_q,
  output logic            o_ratio_rsvd_q,
  output logic [1:0]      o_rate_code_q,
  output logic            o_dc_block_filter_enable_q,
  output logic [7:0]      o_hpf_cut_q,
  output logic            o_amp_rtz_q,
  output logic            o_conv_half_q,
  output logic [1:0]      o_slew_q,
  output logic            o_low_emi_q,
  output logic            o_silent_q
);

  // ------------------------------------------------------------
  // storage and decode
  // ------------------------------------------------------------
  prc_pwr_t   pwr_q;          // power, reset, clock select
  prc_pwr_t   pwr_d;
  prc_sys_t   sys_q;          // system power, edge, clocking
  prc_sys_t   sys_d;
  logic [3:0] det_ratio;      // detected ratio code
  logic [1:0] det_rate;       // detected rate code
  logic       det_locked;     // detector saw a known ratio
  logic       silent;         // silence run complete

  // ratio code to multiple of the sample rate, 0 when reserved
  function automatic logic [9:0] ratio_mult(input logic [3:0] c);
    case (c)
      4'h0:    ratio_mult = 10'h040;
      4'h1:    ratio_mult = 10'h080;
      4'h2:    ratio_mult = 10'h100;
      4'h3:    ratio_mult = 10'h180;
      4'h4:    ratio_mult = 10'h200;
      4'h5:    ratio_mult = 10'h300;
      4'h6:    ratio_mult = 10'h064;
      4'h7:    ratio_mult = 10'h0c8;
      4'h8:    ratio_mult = 10'h190;
      default: ratio_mult = 10'h000;
    endcase
  endfunction

  // address decode, shared by read and write
  wire hit_pwr   = (i_reg_addr == `PRC_OFF_PWR);
  wire hit_sys   = (i_reg_addr == `PRC_OFF_SYS);
  wire hit_any   = hit_pwr || hit_sys;
  wire wr_pwr    = i_reg_wr && hit_pwr;
  wire wr_sys    = i_reg_wr && hit_sys;
  wire wr_soft   = wr_pwr && i_reg_wdata[`PRC_POS_SOFT_RST];
  wire req       = i_reg_wr || i_reg_rd;

  wire [7:0] pwr_rd = {1'b0, 1'b0, pwr_q.no_bclk,
                       pwr_q.master_ratio_field,
                       pwr_q.soft_powerdown_bit};
  wire [7:0] rd_mux = hit_pwr ? pwr_rd :
                      hit_sys ? sys_q  : 8'h00;

  // ------------------------------------------------------------
  // next register values
  // ------------------------------------------------------------
  // soft reset loads defaults
  // reserved bit 6 is kept at zero so it always reads zero
  always_comb begin
    pwr_d = pwr_q;
    sys_d = sys_q;
    if (wr_soft) begin
      pwr_d = prc_pwr_t'(`PRC_PWR_RST);
      sys_d = prc_sys_t'(`PRC_SYS_RST);
    end else if (wr_pwr) begin
      pwr_d      = prc_pwr_t'(i_reg_wdata);
      pwr_d.rsvd = 1'b0;
    end else if (wr_sys) begin
      sys_d = prc_sys_t'(i_reg_wdata);
    end
    pwr_d.soft_rst = 1'b0;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pwr_q <= prc_pwr_t'(`PRC_PWR_RST);
      sys_q <= prc_sys_t'(`PRC_SYS_RST);
    end else begin
      pwr_q <= pwr_d;
      sys_q <= sys_d;
    end
  end

  // ------------------------------------------------------------
  // register port answer
  // ------------------------------------------------------------
  // answer only to requests made
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata_q <= 8'h00;
      o_reg_ack_q   <= 1'b0;
      o_reg_nack_q  <= 1'b0;
    end else begin
      o_reg_rdata_q <= i_reg_rd ? rd_mux : o_reg_rdata_q;
      o_reg_ack_q   <= req && hit_any;
      o_reg_nack_q  <= req && !hit_any;
    end
  end

  // ------------------------------------------------------------
  // helpers: silence and clock detection
  // ------------------------------------------------------------
  // cleared on soft reset, while disabled and while powered down
  wire sil_clear = wr_soft || !sys_q.silence_powerdown_enable ||
                   pwr_q.soft_powerdown_bit;

  prc_silence_det #(
    .COUNT        (SILENT_SAMPLES)
  ) u_silence (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_clear      (sil_clear),
    .i_smp_valid  (i_smp_valid),
    .i_smp_zero   (i_smp_zero),
    .o_silent_q   (silent)
  );

  prc_clock_detect u_detect (
    .i_clk          (i_clk),
    .i_rst          (i_rst),
    .i_clear        (wr_soft),
    .i_mclk_tick    (i_mclk_tick),
    .i_fs_tick      (i_fs_tick),
    .o_ratio_code_q (det_ratio),
    .o_rate_code_q  (det_rate),
    .o_locked_q     (det_locked)
  );

  // ------------------------------------------------------------
  // effective settings
  // ------------------------------------------------------------
  // either auto bit picks detector ratio
  wire       use_det   = sys_q.auto_ratio_detect || sys_q.auto_rate_detect;
  wire [3:0] eff_ratio = use_det ? det_ratio : pwr_q.master_ratio_field;
  wire [1:0] eff_rate  = sys_q.auto_rate_detect ? det_rate : i_fmt_rate;

  wire [7:0] cut = (eff_rate == `PRC_RATE_48K) ? `PRC_CUT_48K :
                   (eff_rate == `PRC_RATE_24K) ? `PRC_CUT_24K :
                                                 `PRC_CUT_12K;

  wire core_pdn = pwr_q.soft_powerdown_bit ||
                  (sys_q.silence_powerdown_enable && silent);

  // ------------------------------------------------------------
  // output flops
  // ------------------------------------------------------------
  // ratio decode and reserved flag
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_soft_rst_q     <= 1'b0;
      o_core_pdn_q     <= 1'b1;
      o_mclk_as_bclk_q <= 1'b0;
      o_ratio_mult_q   <= 10'h100;
      o_ratio_rsvd_q   <= 1'b0;
      o_rate_code_q    <= `PRC_RATE_48K;
      o_dc_block_filter_enable_q       <= 1'b0;
      o_hpf_cut_q      <= `PRC_CUT_48K;
      o_amp_rtz_q      <= 1'b0;
      o_conv_half_q    <= 1'b1;
      o_slew_q         <= 2'h0;
      o_low_emi_q      <= 1'b0;
      o_silent_q       <= 1'b0;
    end else begin
      o_soft_rst_q     <= wr_soft;
      o_core_pdn_q     <= core_pdn;
      o_mclk_as_bclk_q <= pwr_q.no_bclk;
      o_ratio_mult_q   <= ratio_mult(eff_ratio);
      o_ratio_rsvd_q   <= (eff_ratio >= `PRC_RATIO_FIRST_RSVD);
      o_rate_code_q    <= eff_rate;
      o_dc_block_filter_enable_q       <= sys_q.dc_block_filter_enable;
      o_hpf_cut_q      <= cut;
      o_amp_rtz_q      <= sys_q.amplifier_low_power;
      o_conv_half_q    <= sys_q.converter_low_power;
      o_slew_q         <= sys_q.slew;
      o_low_emi_q      <= (sys_q.slew != 2'h0);
      o_silent_q       <= silent;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  chk_soft_rst_defaults: assert property (
    wr_soft |=> (pwr_q == prc_pwr_t'(`PRC_PWR_RST)) &&
                (sys_q == prc_sys_t'(`PRC_SYS_RST)) && o_soft_rst_q)
    else $error("soft reset did not restore defaults");

  chk_no_bclk_out: assert property (
    (wr_pwr && !i_reg_wdata[`PRC_POS_SOFT_RST]) |=> ##1
      (o_mclk_as_bclk_q == $past(i_reg_wdata[`PRC_POS_NO_BCLK], 2)))
    else $error("bit clock substitution not applied");

  chk_ratio_low_map: assert property (
    (!use_det && pwr_q.master_ratio_field == 4'h5) |=>
      (o_ratio_mult_q == 10'h300) && !o_ratio_rsvd_q)
    else $error("ratio 768 decode wrong");

  chk_ratio_high_map: assert property (
    (!use_det && pwr_q.master_ratio_field == 4'h7) |=>
      (o_ratio_mult_q == 10'h0c8))
    else $error("ratio 200 decode wrong");

  chk_ratio_rsvd_flag: assert property (
    (!use_det && pwr_q.master_ratio_field == 4'h9) |=> o_ratio_rsvd_q)
    else $error("reserved ratio not flagged");

  chk_pdn_holds_core: assert property (
    (wr_pwr && !i_reg_wdata[`PRC_POS_SOFT_RST] &&
     i_reg_wdata[`PRC_POS_PDN]) |=> ##1 o_core_pdn_q)
    else $error("power-down bit did not hold core");

  chk_hpf_cutoff: assert property (
    (sys_q.dc_block_filter_enable && eff_rate == `PRC_RATE_24K) |=>
      o_dc_block_filter_enable_q && (o_hpf_cut_q == `PRC_CUT_24K))
    else $error("filter cutoff not scaled");

  chk_amp_conv_modes: assert property (
    $rose(sys_q.amplifier_low_power) |-> ##1 o_amp_rtz_q [*1] ##0
      (o_conv_half_q == $past(sys_q.converter_low_power)))
    else $error("low power modes not driven");

  chk_silence_pdn: assert property (
    (silent && sys_q.silence_powerdown_enable) |=> o_core_pdn_q)
    else $error("silence did not power down");

  chk_slew_emi: assert property (
    (sys_q.slew == 2'h3) |=> (o_slew_q == 2'h3) && o_low_emi_q)
    else $error("slowest slew not selected");

  chk_auto_ratio_pick: assert property (
    (sys_q.auto_ratio_detect && det_ratio == 4'h1) |=>
      (o_ratio_mult_q == 10'h080))
    else $error("detected ratio not used");

  chk_auto_rate_pick: assert property (
    (sys_q.auto_rate_detect && !sys_q.auto_ratio_detect) |=>
      (o_rate_code_q == $past(det_rate)))
    else $error("detected rate not used");

  chk_ack_on_request: assert property (
    (o_reg_ack_q || o_reg_nack_q) |-> $past(req))
    else $error("answer without request");

  chk_rst_bit_zero: assert property (
    (i_reg_rd && hit_pwr) |=> !o_reg_rdata_q[`PRC_POS_SOFT_RST])
    else $error("reset bit read back as one");

  cov_soft_reset: cover property (wr_soft ##1 o_soft_rst_q);
  cov_silence_pdn: cover property ($rose(silent) ##1 o_core_pdn_q);
  cov_auto_locked: cover property (use_det && $rose(det_locked));
  cov_wake_up: cover property ($fell(o_core_pdn_q));

endmodule

// *** design/prc_defines.svh ***
`ifndef PRC_DEFINES_SVH
`define PRC_DEFINES_SVH

// ------------------------------------------------------------
// register offsets and reset values
// ------------------------------------------------------------
`define PRC_OFF_PWR      8'h00
`define PRC_OFF_SYS      8'h01
`define PRC_PWR_RST      8'h05
`define PRC_SYS_RST      8'h30

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PRC_POS_SOFT_RST 7
`define PRC_POS_NO_BCLK  5
`define PRC_POS_PDN      0

// ------------------------------------------------------------
// ratio codes, sample rate codes, filter cutoff (quarter hertz)
// ------------------------------------------------------------
`define PRC_RATIO_FIRST_RSVD 4'h9
`define PRC_RATE_48K     2'h2
`define PRC_RATE_24K     2'h1
`define PRC_RATE_12K     2'h0
`define PRC_CUT_48K      8'h18
`define PRC_CUT_24K      8'h0c
`define PRC_CUT_12K      8'h06

// ------------------------------------------------------------
// timing counts
// ------------------------------------------------------------
`define PRC_SILENT_SAMPLES 2048
`define PRC_CLK_HZ       50000000
`define PRC_FS_MID_HZ    36000
`define PRC_FS_LOW_HZ    18000
`define PRC_MID_CYC      (`PRC_CLK_HZ / `PRC_FS_MID_HZ)
`define PRC_LOW_CYC      (`PRC_CLK_HZ / `PRC_FS_LOW_HZ)

`endif

// *** design/prc_pkg.sv ***
package prc_pkg;

  // power, reset and clock select register layout
  typedef struct packed {
    logic       soft_rst;
    logic       rsvd;
    logic       no_bclk;
    logic [3:0] master_ratio_field;
    logic       soft_powerdown_bit;
  } prc_pwr_t;

  // system power, edge and clocking register layout
  typedef struct packed {
    logic       dc_block_filter_enable;
    logic       amplifier_low_power;
    logic       converter_low_power;
    logic       silence_powerdown_enable;
    logic [1:0] slew;
    logic       auto_ratio_detect;
    logic       auto_rate_detect;
  } prc_sys_t;

  // clock detector states
  typedef enum logic [1:0] {
    PRC_ST_WAIT = 2'b01,
    PRC_ST_MEAS = 2'b10
  } prc_det_st_t;

endpackage

// *** design/prc_silence_det.sv ***
`timescale 1ns/1ps
`include "prc_defines.svh"

module prc_silence_det
  import prc_pkg::*;
#(
  parameter int COUNT = `PRC_SILENT_SAMPLES
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // control
  input  wire logic i_clear,
  // sample stream
  input  wire logic i_smp_valid,
  input  wire logic i_smp_zero,
  // result
  output logic      o_silent_q
);

  localparam int CW = $clog2(COUNT + 1);

  logic [CW-1:0] run_q;   // consecutive zero samples seen
  logic [CW-1:0] run_d;
  wire           at_end = (run_q == CW'(COUNT));

  // ------------------------------------------------------------
  // run length of zero samples
  // ------------------------------------------------------------
  // count zero samples
  assign run_d = i_clear                    ? '0 :
                 !i_smp_valid               ? run_q :
                 !i_smp_zero                ? '0 :
                 at_end                     ? run_q :
                                              run_q + CW'(1);

  // saturates so a long silence never wraps back to sound
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      run_q      <= '0;
      o_silent_q <= 1'b0;
    end else begin
      run_q      <= run_d;
      o_silent_q <= (run_d == CW'(COUNT));
    end
  end

endmodule

// *** tb/power_reset_clock_config_regs_tb.sv ***
`timescale 1ns/1ps

module power_reset_clock_config_regs_tb;
  import prc_pkg::*;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam int SIL = 8;  // short silence run keeps the sim brief
  localparam logic [9:0] MULT [10] = '{10'd64, 10'd128, 10'd256,
    10'd384, 10'd512, 10'd768, 10'd100, 10'd200, 10'd400, 10'd0};
  localparam logic [7:0] CUT [3] = '{8'h06, 8'h0c, 8'h18};
  logic       i_clk, i_rst, i_reg_wr, i_reg_rd, ack, nack;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata_q, rdat, o_hpf_cut_q;
  logic       o_reg_ack_q, o_reg_nack_q, i_smp_valid, i_smp_zero;
  logic       i_mclk_tick, i_fs_tick, o_soft_rst_q, o_core_pdn_q;
  logic       o_mclk_as_bclk_q, o_ratio_rsvd_q, o_dc_block_filter_enable_q, o_amp_rtz_q;
  logic       o_conv_half_q, o_low_emi_q, o_silent_q;
  logic [1:0] i_fmt_rate, o_rate_code_q, o_slew_q;
  logic [9:0] o_ratio_mult_q;
  int         n_errors, n_tests, n_soft;

  prc_config_regs #(.SILENT_SAMPLES(SIL)) u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata_q(o_reg_rdata_q),
    .o_reg_ack_q(o_reg_ack_q), .o_reg_nack_q(o_reg_nack_q),
    .i_fmt_rate(i_fmt_rate), .i_smp_valid(i_smp_valid),
    .i_smp_zero(i_smp_zero), .i_mclk_tick(i_mclk_tick),
    .i_fs_tick(i_fs_tick), .o_soft_rst_q(o_soft_rst_q),
    .o_core_pdn_q(o_core_pdn_q), .o_mclk_as_bclk_q(o_mclk_as_bclk_q),
    .o_ratio_mult_q(o_ratio_mult_q), .o_ratio_rsvd_q(o_ratio_rsvd_q),
    .o_rate_code_q(o_rate_code_q), .o_dc_block_filter_enable_q(o_dc_block_filter_enable_q),
    .o_hpf_cut_q(o_hpf_cut_q), .o_amp_rtz_q(o_amp_rtz_q),
    .o_conv_half_q(o_conv_half_q), .o_slew_q(o_slew_q),
    .o_low_emi_q(o_low_emi_q), .o_silent_q(o_silent_q));

  prc_host_model u_host (
    .i_clk(i_clk), .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd),
    .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata),
    .i_reg_rdata(o_reg_rdata_q), .i_reg_ack(o_reg_ack_q),
    .i_reg_nack(o_reg_nack_q));

  // ------------------------------------------------------------
  // clock, pulse monitor, helpers
  // ------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // counts soft reset cycles, so a stuck pulse shows up too
  always @(posedge i_clk) begin
    if (o_soft_rst_q === 1'b1) n_soft++;
  end

  task automatic check(input logic [9:0] seen, input logic [9:0] exp,
                       input string what);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask

  // write, then one more edge so derived outputs settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, d, rdat, ack, nack);
    @(posedge i_clk);
    @(negedge i_clk);
  endtask

  task automatic rd(input logic [7:0] a);
    u_host.xfer(1'b0, a, 8'h00, rdat, ack, nack);
  endtask

  task automatic samples(input int n, input logic zero);
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk);
      i_smp_valid <= 1'b1;
      i_smp_zero <= zero;
      @(posedge i_clk);
      i_smp_valid <= 1'b0;
      i_smp_zero <= ~zero;
    end
    repeat (3) @(negedge i_clk);
  endtask

  // one master tick per cycle, so len ticks make one frame
  task automatic frames(input int n, input int len);
    for (int i = 0; i < n * len; i++) begin
      @(posedge i_clk);
      i_mclk_tick <= 1'b1;
      i_fs_tick <= (i % len == 0);
    end
    @(posedge i_clk);
    i_mclk_tick <= 1'b0;
    i_fs_tick <= 1'b0;
    repeat (3) @(negedge i_clk);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rd(8'h00);
    check(rdat, 8'h05, "pwr default");
    check(ack, 1'b1, "ack");
    rd(8'h01);
    check(rdat, 8'h30, "sys default");
    check(o_core_pdn_q, 1'b1, "pdn");
    check(o_ratio_mult_q, 10'd256, "ratio");
    check(o_conv_half_q, 1'b1, "half");
  endtask

  task automatic t_ratio();
    for (int c = 0; c < 10; c++) begin
      wr(8'h00, {3'b000, c[3:0], 1'b0});
      check(o_ratio_mult_q, MULT[c], "mult");
      check(o_ratio_rsvd_q, c == 9, "rsvd");
    end
    check(o_core_pdn_q, 1'b0, "pdn off");
  endtask

  task automatic t_sys();
    for (int s = 0; s < 4; s++) begin
      wr(8'h01, {4'b1100, s[1:0], 2'b00});
      check(o_slew_q, s[1:0], "slew");
      check(o_low_emi_q, s != 0, "emi");
    end
    check(o_dc_block_filter_enable_q, 1'b1, "hpf");
    check(o_amp_rtz_q, 1'b1, "rtz");
    check(o_conv_half_q, 1'b0, "half off");
    for (int r = 0; r < 3; r++) begin
      @(posedge i_clk);
      i_fmt_rate <= r[1:0];
      repeat (3) @(negedge i_clk);
      check(o_rate_code_q, r[1:0], "rate");
      check(o_hpf_cut_q, CUT[r], "cutoff");
    end
  endtask

  // reserved bit 6 is written too and must read as zero
  task automatic t_nobclk();
    wr(8'h00, 8'h60);
    check(o_mclk_as_bclk_q, 1'b1, "no bclk");
    rd(8'h00);
    check(rdat, 8'h20, "pwr readback");
    wr(8'h02, 8'hff);
    check(nack, 1'b1, "nack");
    check(ack, 1'b0, "no ack");
    rd(8'h00);
    check(rdat, 8'h20, "unchanged");
  endtask

  task automatic t_soft();
    wr(8'h01, 8'hcf);
    n_soft = 0;
    wr(8'h00, 8'ha0);
    check(n_soft, 1, "pulse");
    rd(8'h00);
    check(rdat, 8'h05, "pwr back");
    rd(8'h01);
    check(rdat, 8'h30, "sys back");
    check(o_mclk_as_bclk_q, 1'b0, "bclk back");
  endtask

  task automatic t_silence();
    wr(8'h00, 8'h04);
    samples(SIL - 1, 1'b1);
    check(o_silent_q, 1'b0, "short run");
    samples(1, 1'b1);
    check(o_silent_q, 1'b1, "silent");
    check(o_core_pdn_q, 1'b1, "silent pdn");
    samples(1, 1'b0);
    check(o_core_pdn_q, 1'b0, "wake");
  endtask

  task automatic t_auto();
    @(posedge i_clk);
    i_fmt_rate <= 2'b00;
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h02);
    frames(4, 128);
    check(o_ratio_mult_q, 10'd128, "auto ratio");
    check(o_rate_code_q, 2'b00, "fmt rate");
    wr(8'h01, 8'h01);
    frames(4, 128);
    check(o_rate_code_q, 2'b10, "auto rate");
    check(o_ratio_mult_q, 10'd128, "rate ratio");
    wr(8'h01, 8'h00);
    check(o_ratio_mult_q, 10'd64, "manual");
  endtask

  // ------------------------------------------------------------
  // sequence, watchdog, verdict
  // ------------------------------------------------------------
  task automatic results();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    n_errors = 0;
    n_tests = 0;
    n_soft = 0;
    i_rst = 1'b1;
    i_fmt_rate = 2'b10;
    i_smp_valid = 1'b0;
    i_smp_zero = 1'b0;
    i_mclk_tick = 1'b0;
    i_fs_tick = 1'b0;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_ratio();
    t_sys();
    t_nobclk();
    t_soft();
    t_silence();
    t_auto();
    results();
  end

  // about seventeen times the expected run
  initial begin
    repeat (20000) @(posedge i_clk);
    n_errors++;
    $display("ERROR at %0t: watchdog expired", $time);
    results();
  end
endmodule

// *** tb/prc_host_model.sv ***
`timescale 1ns/1ps

// ------------------------------------------------------------
// host side of the register port
// ------------------------------------------------------------
module prc_host_model (
  // clock
  input  wire logic       i_clk,
  // request lines
  output logic            o_reg_wr,
  output logic            o_reg_rd,
  output logic [7:0]      o_reg_addr,
  output logic [7:0]      o_reg_wdata,
  // answer lines
  input  wire logic [7:0] i_reg_rdata,
  input  wire logic       i_reg_ack,
  input  wire logic       i_reg_nack
);
  // idle before the first request
  initial begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 8'h00;
  end

  // caller supplies direction, address and data; gets read data and answer back
  task automatic xfer(input logic wr, input logic [7:0] addr,
                      input logic [7:0] data, output logic [7:0] rdata,
                      output logic ack, output logic nack);
    @(posedge i_clk);
    o_reg_wr <= wr;
    o_reg_rd <= ~wr;
    o_reg_addr <= addr;
    o_reg_wdata <= data;
    @(posedge i_clk);
    o_reg_wr <= 1'b0;
    o_reg_rd <= 1'b0;
    // released lines show the inverse so stale values cannot pass
    o_reg_addr <= ~addr;
    o_reg_wdata <= ~data;
    // answer stands one cycle; settled by the falling edge
    @(negedge i_clk);
    rdata = i_reg_rdata;
    ack = i_reg_ack;
    nack = i_reg_nack;
  endtask
endmodule
